/* pssie_defines.vh */
`ifndef PSSIE_DEFINES_VH
`define PSSIE_DEFINES_VH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define PSSIE_IDX_STATUS      8'h11
`define PSSIE_IDX_IRQ_EN      8'h12
`define PSSIE_IDX_EVT_STATUS  8'h13
`define PSSIE_IDX_CFG         8'h14
// ----------------------------------------
// status word fields
// ----------------------------------------
`define PSSIE_ST_SPEED_HI     15
`define PSSIE_ST_SPEED_LO     14
`define PSSIE_ST_DUPLEX       13
`define PSSIE_ST_PAGE         12
`define PSSIE_ST_RESOLVED     11
`define PSSIE_ST_LINK         10
`define PSSIE_ST_XCD          9
`define PSSIE_ST_XAB          8
`define PSSIE_ST_DOWNSHIFT    7
`define PSSIE_ST_SLEEP        6
`define PSSIE_ST_POL_HI       5
`define PSSIE_ST_POL_LO       2
`define PSSIE_ST_RXPOL10      1
`define PSSIE_ST_JABBER       0
// ----------------------------------------
// enable / event layout and resets
// ----------------------------------------
`define PSSIE_EVT_MASK        16'hFD7F
`define PSSIE_SPEED_1000      2'h2
`define PSSIE_IRQ_EN_RST      16'h0000
`define PSSIE_CFG_POL_BIT     13
`define PSSIE_CFG_RST         16'h2000
`endif

/* pssie_top.v */
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
// Contract
// - speed in bits 15:14, 10 is gigabit
// - bit 13 shows full duplex
// - bit 12 latches page received, read clears
// - bit 11 set when negotiation done/disabled
// - bit 10 shows live link state
// - bits 9/8 crossover for CD/AB pairs
// - bit 7 downshift active during negotiation
// - bit 6 shows sleep mode
// - bits 5:2 channel polarity on gigabit link
// - bit 1 ten-meg polarity, resets to 1
// - bit 0 jabber, not cleared by read
// - interrupt only for enabled occurring events
// - enables 15:10 gate negotiation/link events
// - enables 8,6..0 gate remaining events
// - event flags set regardless, read clears
// - irq polarity config bit 13, default low
module pssie_top #(
   parameter ADDR_W = 8
) (
   input  wire              clk,
   input  wire              rst_n,
   input  wire              clk_en,
   input  wire [ADDR_W-1:0] avs_address,
   input  wire              avs_read,
   input  wire              avs_write,
   input  wire [31:0]       avs_writedata,
   input  wire [3:0]        avs_byteenable,
   output reg  [31:0]       avs_readdata,
   output reg               avs_waitrequest,
   output reg  [1:0]        avs_response,
   input  wire [1:0]        resolved_speed,
   input  wire              full_duplex,
   input  wire              page_received,
   input  wire              neg_resolved,
   input  wire              link_up,
   input  wire              crossover_pairs_cd,
   input  wire              crossover_pairs_ab,
   input  wire              downshift_active,
   input  wire              sleep_active,
   input  wire [3:0]        channel_polarity_reversed,
   input  wire              rx_pol_ok_10m,
   input  wire              jabber_detect,
   input  wire              neg_error_evt,
   input  wire              false_carrier_evt,
   input  wire              wake_packet_evt,
   input  wire              mac_if_error_evt,
   output reg               irq_pin,
   output reg               irq
);
`include "pssie_defines.vh"

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
localparam SW = 26;
wire [SW-1:0] raw_in = {resolved_speed, full_duplex, page_received, neg_resolved, link_up,
                        crossover_pairs_cd, crossover_pairs_ab, downshift_active, sleep_active,
                        channel_polarity_reversed, rx_pol_ok_10m, jabber_detect, neg_error_evt,
                        false_carrier_evt, wake_packet_evt, mac_if_error_evt, 6'h00};
reg  [SW-1:0] sync1;
reg  [SW-1:0] sync2;
reg  [SW-1:0] prev;
// bit 11 (rx polarity) resets high so no spurious edge
localparam [SW-1:0] SYNC_RST = 26'h0000800;
always @(posedge clk or negedge rst_n) begin
   if (!rst_n) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      prev  <= SYNC_RST;
   end else if (clk_en) begin
      sync1 <= raw_in;
      sync2 <= sync1;
      prev  <= sync2;
   end
end

wire [1:0] s_speed    = sync2[25:24];
wire       s_duplex   = sync2[23];
wire       s_page     = sync2[22];
wire       s_resolved = sync2[21];
wire       s_link     = sync2[20];
wire       s_xcd      = sync2[19];
wire       s_xab      = sync2[18];
wire       s_dshift   = sync2[17];
wire       s_sleep    = sync2[16];
wire [3:0] s_pol      = sync2[15:12];
wire       s_rxpol    = sync2[11];
wire       s_jabber   = sync2[10];
wire [3:0] s_pulse    = sync2[9:6] & ~prev[9:6];
wire [SW-1:0] chg     = sync2 ^ prev;

// ----------------------------------------
// event vector in enable-register layout
// ----------------------------------------
wire [15:0] evt_now;
assign evt_now[15] = s_pulse[3];
assign evt_now[14] = |chg[25:24];
assign evt_now[13] = chg[23];
assign evt_now[12] = s_page & ~prev[22];
assign evt_now[11] = s_resolved & ~prev[21];
assign evt_now[10] = chg[20];
assign evt_now[9]  = 1'b0;
assign evt_now[8]  = s_pulse[2];
assign evt_now[7]  = 1'b0;
assign evt_now[6]  = chg[19] | chg[18];
assign evt_now[5]  = s_dshift & ~prev[17];
assign evt_now[4]  = chg[16];
assign evt_now[3]  = s_pulse[1];
assign evt_now[2]  = s_pulse[0];
assign evt_now[1]  = (|chg[15:12]) | chg[11];
assign evt_now[0]  = s_jabber & ~prev[10];

// ----------------------------------------
// bus decode
// ----------------------------------------
wire [ADDR_W-3:0] idx  = avs_address[ADDR_W-1:2];
wire       hit_st  = (idx == `PSSIE_IDX_STATUS);
wire       hit_en  = (idx == `PSSIE_IDX_IRQ_EN);
wire       hit_ev  = (idx == `PSSIE_IDX_EVT_STATUS);
wire       hit_cfg = (idx == `PSSIE_IDX_CFG);
wire       mapped  = hit_st | hit_en | hit_ev | hit_cfg;
// one wait cycle per access; the accept cycle has waitrequest low
wire       accept  = (avs_read | avs_write) & ~avs_waitrequest;
// read data is captured one edge early so it stands at the accept edge;
// clearing at that same edge means no event can slip in unread
wire       prep    = (avs_read | avs_write) & avs_waitrequest;
wire       rd_st   = prep & avs_read & hit_st;
wire       rd_ev   = prep & avs_read & hit_ev;
wire       wr_lo   = accept & avs_write & avs_byteenable[0];
wire       wr_hi   = accept & avs_write & avs_byteenable[1];

reg  [15:0] irq_en;
reg  [15:0] cfg;
reg  [15:0] evt_flags;
reg         page_latch;
reg  [15:0] next_evt_flags;
reg         next_page_latch;

always @* begin
   // set wins over a clearing read in the same cycle
   next_evt_flags  = (rd_ev ? 16'h0000 : evt_flags) | (evt_now & `PSSIE_EVT_MASK);
   next_page_latch = (rd_st ? 1'b0 : page_latch) | evt_now[12];
end

wire [15:0] status_word;
assign status_word[15:14] = s_speed;
assign status_word[13]    = s_duplex;
assign status_word[12]    = page_latch;
assign status_word[11]    = s_resolved;
assign status_word[10]    = s_link;
assign status_word[9]     = s_xcd;
assign status_word[8]     = s_xab;
assign status_word[7]     = s_dshift & ~s_resolved;
assign status_word[6]     = s_sleep;
assign status_word[5:2]   = (s_link && s_speed == `PSSIE_SPEED_1000) ? s_pol : 4'h0;
assign status_word[1]     = s_rxpol;
assign status_word[0]     = s_jabber;

reg [15:0] rd_mux;
always @* begin
   case (1'b1)
      hit_st:  rd_mux = status_word;
      hit_en:  rd_mux = irq_en;
      hit_ev:  rd_mux = evt_flags;
      hit_cfg: rd_mux = cfg;
      default: rd_mux = 16'h0000;
   endcase
end

wire [15:0] en_wdata = {wr_hi ? avs_writedata[15:8] : irq_en[15:8],
                        wr_lo ? avs_writedata[7:0]  : irq_en[7:0]};
wire [15:0] cf_wdata = {wr_hi ? avs_writedata[15:8] : cfg[15:8],
                        wr_lo ? avs_writedata[7:0]  : cfg[7:0]};
wire        pending  = |(evt_flags & irq_en);

// ----------------------------------------
// registers and bus response
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
   if (!rst_n) begin
      irq_en          <= `PSSIE_IRQ_EN_RST;
      cfg             <= `PSSIE_CFG_RST;
      evt_flags       <= 16'h0000;
      page_latch      <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'h0;
      irq             <= 1'b0;
      irq_pin         <= 1'b1;
   end else if (clk_en) begin
      evt_flags  <= next_evt_flags;
      page_latch <= next_page_latch;
      // status register has no write path
      if (accept & avs_write & hit_en)
         irq_en <= en_wdata & `PSSIE_EVT_MASK;
      if (accept & avs_write & hit_cfg)
         cfg <= cf_wdata & `PSSIE_CFG_RST;
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (prep & avs_read) begin
         avs_readdata <= {16'h0000, rd_mux};
         avs_response <= mapped ? 2'h0 : 2'h2;
      end else if (prep) begin
         avs_response <= mapped ? 2'h0 : 2'h2;
      end
      irq     <= pending;
      irq_pin <= cfg[`PSSIE_CFG_POL_BIT] ? ~pending : pending;
   end
end

endmodule // pssie_top

/* pssie_monitor.sv */
`timescale 1ns/100ps
module pssie_monitor (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  avs_response,
   input wire logic        irq_pin,
   input wire logic        irq
);
   wire [5:0] idx = avs_address[7:2];
   wire       req = avs_read || avs_write;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_acc; !avs_waitrequest; endsequence
   sequence s_back; $rose(avs_waitrequest); endsequence
   property p_once; s_acc |=> avs_waitrequest; endproperty
   a_once: assert property (p_once) else $error("accept held twice");
   property p_cause; s_acc |-> $past(req); endproperty
   a_cause: assert property (p_cause) else $error("accept without request");
   property p_upper; s_back |-> avs_readdata[31:16] == 16'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper half not zero");
   property p_err; $rose(avs_waitrequest) && avs_response == 2'h2 |-> avs_readdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("refused read carries data");
   property p_ok; $rose(avs_waitrequest) && $past(idx) >= 6'h11 && $past(idx) <= 6'h14 |-> avs_response == 2'h0;
   endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_hold; avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved while idle");
   property p_fall; $fell(irq) |-> !$past(avs_waitrequest, 1) || !$past(avs_waitrequest, 2); endproperty
   a_fall: assert property (p_fall) else $error("irq dropped without access");
   property p_rst; $rose(rst_n) |-> irq_pin && !irq; endproperty
   a_rst: assert property (p_rst) else $error("irq not idle after reset");
endmodule // pssie_monitor
bind pssie_top pssie_monitor u_pssie_monitor (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .irq_pin(irq_pin), .irq(irq));

/* pssie_master.sv */
`timescale 1ns/100ps
module pssie_master (
   input  wire logic        clk,
   input  wire logic [25:0] cmd,
   input  wire logic        avs_waitrequest,
   output logic             avs_read = 1'h0,
   output logic             avs_write = 1'h0,
   output logic [7:0]       avs_address = 8'h0,
   output logic [31:0]      avs_writedata = 32'h0,
   output logic             done = 1'h0
);
   always @(posedge clk) begin
      done <= 1'h0;
      if ((avs_read || avs_write) && !avs_waitrequest) begin
         avs_read <= 1'h0;
         avs_write <= 1'h0;
         // released address flips so a stale value is never mistaken for a live one
         avs_address <= ~avs_address;
         done <= 1'h1;
      end else if (cmd[25] && !avs_read && !avs_write) begin
         avs_read <= !cmd[24];
         avs_write <= cmd[24];
         avs_address <= cmd[23:16];
         avs_writedata <= {16'h0, cmd[15:0]};
      end
   end
endmodule // pssie_master

/* tb.sv */
`timescale 1ns/100ps
module tb;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [25:0] cmd = 26'h0;
   logic [15:0] sv = 16'h0;
   logic        pg = 1'h0;
   logic [3:0]  ev = 4'h0;
   logic [31:0] rs = 32'h8538AF64;
   logic [34:0] q[$];
   logic [34:0] ent;
   logic        rd, wt, wq, dn, irq, ipin;
   logic [7:0]  ad;
   logic [31:0] wdat, rdat;
   logic [1:0]  resp;
   int          err_count = 0;
   int          checked = 0;
   localparam logic [15:0] EB [4] = '{16'h8000, 16'h0100, 16'h0008, 16'h0004};
   always #4 clk = ~clk;
   pssie_master u_pssie_master (.clk(clk), .cmd(cmd), .avs_waitrequest(wq), .avs_read(rd), .avs_write(wt),
      .avs_address(ad), .avs_writedata(wdat), .done(dn));
   pssie_top u_pssie_top (.clk(clk), .rst_n(rst_n), .clk_en(1'h1), .avs_address(ad), .avs_read(rd),
      .avs_write(wt), .avs_writedata(wdat), .avs_byteenable(4'h3), .avs_readdata(rdat), .avs_waitrequest(wq),
      .avs_response(resp), .resolved_speed(sv[15:14]), .full_duplex(sv[13]), .page_received(pg),
      .neg_resolved(sv[11]), .link_up(sv[10]), .crossover_pairs_cd(sv[9]), .crossover_pairs_ab(sv[8]),
      .downshift_active(sv[7]), .sleep_active(sv[6]), .channel_polarity_reversed(sv[5:2]),
      .rx_pol_ok_10m(sv[1]), .jabber_detect(sv[0]), .neg_error_evt(ev[0]), .false_carrier_evt(ev[1]),
      .wake_packet_evt(ev[2]), .mac_if_error_evt(ev[3]), .irq_pin(ipin), .irq(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] st(input logic [15:0] v);
      st = v;
      st[7] = v[7] & ~v[11];
      if (v[15:14] != 2'h2 || !v[10]) st[5:2] = 4'h0;
   endfunction
   task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected read at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task automatic cmp_pin(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected level at %0t: %b vs %b", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [34:0] e);
      if (!w) q.push_back(e);
      cmd <= {1'h1, w, a, d};
      @(posedge clk);
      cmd[25] <= 1'h0;
      for (int k = 0; k < 40 && !dn; k++) @(posedge clk);
      if (!dn) err_count++;
      rs = lfsr(rs);
      repeat (rs[1:0]) @(posedge clk);
   endtask
   task automatic rdr(input logic [7:0] a, input logic [15:0] x);
      bus(1'h0, a, 16'h0, {3'h4, 16'h0, x});
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rd && !wq) begin
         ent = q.pop_front();
         if (ent[34]) cmp_rd({resp, rdat}, ent[33:0]);
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      cmp_pin(ipin, 1'h1);
      rdr(8'h48, 16'h0);
      rdr(8'h50, 16'h2000);
      bus(1'h1, 8'h48, 16'hFFFF, 35'h0);
      rdr(8'h48, 16'hFD7F);
      for (int i = 0; i < 6; i++) begin
         rs = lfsr(rs);
         sv <= {2'(i % 3), rs[13:0] & 14'h2FFF | (i == 2 ? 14'h0C00 : 14'h0)};
         repeat (4) @(posedge clk);
         rdr(8'h44, st(sv));
      end
      bus(1'h1, 8'h44, 16'hFFFF, 35'h0);
      rdr(8'h44, st(sv));
      pg <= 1'h1;
      sv[0] <= 1'h1;
      repeat (2) @(posedge clk);
      pg <= 1'h0;
      repeat (4) @(posedge clk);
      rdr(8'h44, st(sv) | 16'h1000);
      rdr(8'h44, st(sv));
      bus(1'h0, 8'hFC, 16'h0, {3'h6, 32'h0});
      bus(1'h1, 8'hFC, 16'h1234, 35'h0);
      bus(1'h1, 8'h48, 16'h0, 35'h0);
      // unchecked read: only clears flags left by the status traffic
      bus(1'h0, 8'h4C, 16'h0, 35'h0);
      ev <= 4'hF;
      repeat (8) @(posedge clk);
      ev <= 4'h0;
      repeat (8) @(posedge clk);
      cmp_pin(irq, 1'h0);
      rdr(8'h4C, 16'h810C);
      for (int i = 0; i < 4; i++) begin
         bus(1'h1, 8'h48, EB[i], 35'h0);
         ev[i] <= 1'h1;
         repeat (8) @(posedge clk);
         cmp_pin(irq, 1'h1);
         cmp_pin(ipin, 1'h0);
         ev[i] <= 1'h0;
         rdr(8'h4C, EB[i]);
         repeat (4) @(posedge clk);
         cmp_pin(irq, 1'h0);
      end
      bus(1'h1, 8'h50, 16'h0, 35'h0);
      repeat (4) @(posedge clk);
      cmp_pin(ipin, 1'h0);
      ev[3] <= 1'h1;
      repeat (8) @(posedge clk);
      cmp_pin(ipin, 1'h1);
      test_done;
   end
endmodule // tb
